// File: core/ssi_top.sv
/*
 Startup status indicator: encodes boot phases and startup errors on the
 front-panel lamps, then hands the user lamps to the application.
 Assumes the boot sequencer and application run on clk_in; network and
 fieldbus status arrive from pins and are synchronised here.
*/
`timescale 1ns/1ps
// What this block does
// - On successful startup all user lamps and error lamp go dark.
// - After ready, user lamps follow application-written values.
// - Run-time start failure lights lamp one and error lamp only.
// - Coprocessor load failure lights lamp two and error lamp only.
// - Logic loaded: lamp one lit, others and error dark.
// - Coprocessor loaded: lamps one and two lit, three and error dark.
// - Flash initialising: all user lamps lit, error lamp dark.
// - Driver load failure lights both transmit status lamps.
// - Network activity lamp lit while receiving or transmitting.
// - Seven fieldbus lamps reserved, meaning set by fitted fieldbus.
// - Network link lamp lit while a link pulse is present.
module ssi_top
	import ssi_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic ce_in,
	input wire logic [2:0] boot_event_in,
	input wire logic [UL_W-1:0] app_lamps_in,
	input wire logic app_lamps_we_in,
	input wire logic [1:0] tx_status_in,
	input wire logic net_rx_in,
	input wire logic net_tx_in,
	input wire logic net_link_in,
	input wire logic [FB_LAMPS-1:0] fieldbus_in,
	output logic user_lamp_one_out,
	output logic user_lamp_two_out,
	output logic user_lamp_three_out,
	output logic error_lamp_out,
	output logic transmit_status_lamp_a_out,
	output logic transmit_status_lamp_b_out,
	output logic network_activity_lamp_out,
	output logic network_link_lamp_out,
	output logic [FB_LAMPS-1:0] fieldbus_lamps_out,
	output logic app_owns_lamps_out
);
	// ==========================================================
	// Pin synchronisation
	localparam int PIN_W = 3 + FB_LAMPS;
	logic [PIN_W-1:0] pins_s;
	logic rx_s;
	logic tx_s;
	logic link_s;
	logic [FB_LAMPS-1:0] fb_s;

	ssi_sync #(.W(PIN_W)) u_sync (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.ce_in(ce_in),
		.d_in({net_rx_in, net_tx_in, net_link_in, fieldbus_in}),
		.q_out(pins_s)
	);
	assign {rx_s, tx_s, link_s, fb_s} = pins_s;

	// ==========================================================
	// Boot phase state
	ssi_state_t state_r;
	ssi_state_t state_nxt;
	logic drv_fail_r;
	logic drv_fail_nxt;
	logic [UL_W-1:0] app_r;
	logic [UL_W-1:0] app_nxt;
	logic [LAMP_W-1:0] pat_r;
	logic [LAMP_W-1:0] pat_nxt;
	logic [1:0] txl_r;
	logic [1:0] txl_nxt;
	logic act_r;
	logic act_nxt;
	logic link_r;
	logic link_nxt;
	logic [FB_LAMPS-1:0] fb_r;
	logic [FB_LAMPS-1:0] fb_nxt;
	ssi_event_t ev;

	function automatic logic is_error(input ssi_state_t s);
		return (s == SSI_ST_RT_ERR) || (s == SSI_ST_TC_ERR);
	endfunction

	always_comb begin
		ev = ssi_event_t'(boot_event_in);
		state_nxt = state_r;
		drv_fail_nxt = drv_fail_r;
		app_nxt = app_r;
		if (ce_in) begin
			// Errors are terminal until reset
			if (!is_error(state_r)) begin
				case (ev)
					SSI_EV_RT_FAIL: state_nxt = SSI_ST_RT_ERR;
					SSI_EV_TC_FAIL: state_nxt = SSI_ST_TC_ERR;
					SSI_EV_PL_OK: state_nxt = SSI_ST_PL_OK;
					SSI_EV_TC_OK: state_nxt = SSI_ST_TC_OK;
					SSI_EV_FLASH_START: state_nxt = SSI_ST_FLASH;
					SSI_EV_READY: state_nxt = SSI_ST_READY;
					default: state_nxt = state_r;
				endcase
			end
			if (ev == SSI_EV_DRV_FAIL) begin
				drv_fail_nxt = 1'b1;
			end
			// Writes before ready are not shown
			if (app_lamps_we_in) begin
				app_nxt = app_lamps_in;
			end
			// Entering ready starts from dark lamps, so a write in that same cycle is lost
			if (state_r != SSI_ST_READY && state_nxt == SSI_ST_READY) begin
				app_nxt = '0;
			end
		end
	end

	// ==========================================================
	// Lamp drive
	always_comb begin
		pat_nxt = pat_r;
		txl_nxt = txl_r;
		act_nxt = act_r;
		link_nxt = link_r;
		fb_nxt = fb_r;
		if (ce_in) begin
			case (state_nxt)
				SSI_ST_BOOT: pat_nxt = PAT_BOOT;
				SSI_ST_RT_ERR: pat_nxt = PAT_RT_ERR;
				SSI_ST_TC_ERR: pat_nxt = PAT_TC_ERR;
				SSI_ST_PL_OK: pat_nxt = PAT_PL_OK;
				SSI_ST_TC_OK: pat_nxt = PAT_TC_OK;
				SSI_ST_FLASH: pat_nxt = PAT_FLASH;
				// Application drives user lamps; error lamp stays dark
				SSI_ST_READY: pat_nxt = {app_nxt, PAT_READY[LAMP_ERR_BIT]};
				default: pat_nxt = PAT_BOOT;
			endcase
			// Driver failure overrides the transmit status lamps
			txl_nxt = drv_fail_nxt ? '1 : tx_status_in;
			act_nxt = rx_s | tx_s;
			link_nxt = link_s;
			fb_nxt = fb_s;
		end
	end

	// Reset also clears app values so a stale pattern cannot reappear
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			state_r <= SSI_ST_BOOT;
			drv_fail_r <= 1'b0;
			app_r <= '0;
			pat_r <= PAT_BOOT;
			txl_r <= '0;
			act_r <= 1'b0;
			link_r <= 1'b0;
			fb_r <= '0;
		end else begin
			state_r <= state_nxt;
			drv_fail_r <= drv_fail_nxt;
			app_r <= app_nxt;
			pat_r <= pat_nxt;
			txl_r <= txl_nxt;
			act_r <= act_nxt;
			link_r <= link_nxt;
			fb_r <= fb_nxt;
		end
	end

	assign user_lamp_one_out = pat_r[LAMP_ONE_BIT];
	assign user_lamp_two_out = pat_r[LAMP_TWO_BIT];
	assign user_lamp_three_out = pat_r[LAMP_THREE_BIT];
	assign error_lamp_out = pat_r[LAMP_ERR_BIT];
	assign {transmit_status_lamp_a_out, transmit_status_lamp_b_out} = txl_r;
	assign network_activity_lamp_out = act_r;
	assign network_link_lamp_out = link_r;
	assign fieldbus_lamps_out = fb_r;
	assign app_owns_lamps_out = (state_r == SSI_ST_READY);

	// ==========================================================
	// Assertions
	logic [LAMP_W-1:0] lamps_w;
	assign lamps_w = {user_lamp_one_out, user_lamp_two_out, user_lamp_three_out, error_lamp_out};

	rt_err_pat_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(state_r == SSI_ST_RT_ERR) |-> (lamps_w == PAT_RT_ERR))
		else $error("run-time error pattern wrong");
	tc_err_pat_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(state_r == SSI_ST_TC_ERR) |-> (lamps_w == PAT_TC_ERR))
		else $error("coprocessor error pattern wrong");
	pl_ok_pat_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(ce_in && !is_error(state_r) && ev == SSI_EV_PL_OK) |=> (lamps_w == PAT_PL_OK))
		else $error("logic loaded pattern wrong");
	tc_ok_pat_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(ce_in && !is_error(state_r) && ev == SSI_EV_TC_OK) |=> (lamps_w == PAT_TC_OK))
		else $error("coprocessor loaded pattern wrong");
	flash_pat_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(state_r == SSI_ST_FLASH) |-> (lamps_w == PAT_FLASH))
		else $error("flash init pattern wrong");
	ready_app_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(state_r == SSI_ST_READY) |-> ({user_lamp_one_out, user_lamp_two_out, user_lamp_three_out} == app_r
		&& !error_lamp_out))
		else $error("ready lamps not from application");
	error_sticky_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		is_error(state_r) |=> (state_r == $past(state_r)))
		else $error("error state left before reset");
	drv_fail_tx_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(ce_in && ev == SSI_EV_DRV_FAIL) |=> (transmit_status_lamp_a_out && transmit_status_lamp_b_out)[*2])
		else $error("driver failure not on transmit lamps");
	net_act_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(ce_in && $past(ce_in) && $past(ce_in, 2) && $past(ce_in, 3) && $past(rst_b_in) && $past(rst_b_in, 2)
		&& $past(rst_b_in, 3)) |->
		(network_activity_lamp_out == ($past(net_rx_in, 3) | $past(net_tx_in, 3))))
		else $error("activity lamp mismatch");
	ready_entry_dark_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(ce_in && !is_error(state_r) && state_r != SSI_ST_READY && ev == SSI_EV_READY) |=> (lamps_w == PAT_READY))
		else $error("ready entry lamps not dark");
	reset_boot_a: assert property (@(posedge clk_in)
		!rst_b_in |=> (!app_owns_lamps_out && lamps_w == PAT_BOOT))
		else $error("reset did not restart boot encoding");

	ready_c: cover property (@(posedge clk_in) disable iff (!rst_b_in) state_r == SSI_ST_READY);
	rt_err_c: cover property (@(posedge clk_in) disable iff (!rst_b_in) state_r == SSI_ST_RT_ERR);
	flash_ready_c: cover property (@(posedge clk_in) disable iff (!rst_b_in)
		(state_r == SSI_ST_FLASH) ##[1:20] (state_r == SSI_ST_READY));
	drv_fail_c: cover property (@(posedge clk_in) disable iff (!rst_b_in) drv_fail_r);
endmodule

// File: shared/ssi_pkg.sv
/*
 Shared constants and types for the startup status indicator.
 Assumes a single 250 MHz clock domain and no software-visible registers.
*/
package ssi_pkg;
	// ==========================================================
	// Lamp pattern bit positions {one, two, three, error}
	localparam int LAMP_ONE_BIT = 3;
	localparam int LAMP_TWO_BIT = 2;
	localparam int LAMP_THREE_BIT = 1;
	localparam int LAMP_ERR_BIT = 0;
	localparam int LAMP_W = 4;
	localparam int FB_LAMPS = 7;
	localparam int UL_W = 3;

	// ==========================================================
	// Lamp patterns per phase
	localparam logic [LAMP_W-1:0] PAT_BOOT = 4'h0;
	localparam logic [LAMP_W-1:0] PAT_READY = 4'h0;
	localparam logic [LAMP_W-1:0] PAT_RT_ERR = 4'h9;
	localparam logic [LAMP_W-1:0] PAT_TC_ERR = 4'h5;
	localparam logic [LAMP_W-1:0] PAT_PL_OK = 4'h8;
	localparam logic [LAMP_W-1:0] PAT_TC_OK = 4'hC;
	localparam logic [LAMP_W-1:0] PAT_FLASH = 4'hE;

	// ==========================================================
	// Boot phase reports from the sequencer
	typedef enum logic [2:0] {
		SSI_EV_NONE,
		SSI_EV_RT_FAIL,
		SSI_EV_TC_FAIL,
		SSI_EV_PL_OK,
		SSI_EV_TC_OK,
		SSI_EV_FLASH_START,
		SSI_EV_READY,
		SSI_EV_DRV_FAIL
	} ssi_event_t;

	typedef enum {
		SSI_ST_BOOT,
		SSI_ST_PL_OK,
		SSI_ST_TC_OK,
		SSI_ST_FLASH,
		SSI_ST_READY,
		SSI_ST_RT_ERR,
		SSI_ST_TC_ERR
	} ssi_state_t;
endpackage

// File: core/ssi_sync.sv
/*
 Two-flop synchroniser for a vector of pin inputs.
 Assumes inputs are asynchronous levels; output lags by two enabled edges.
*/
`timescale 1ns/1ps
module ssi_sync #(
	parameter int W = 1
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic ce_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_r;
	logic [W-1:0] q_nxt;

	always_comb begin
		meta_nxt = meta_r;
		q_nxt = q_r;
		if (ce_in) begin
			meta_nxt = d_in;
			q_nxt = meta_r;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			meta_r <= '0;
			q_r <= '0;
		end else begin
			meta_r <= meta_nxt;
			q_r <= q_nxt;
		end
	end

	assign q_out = q_r;
endmodule

// File: tb/ssi_boot_model.sv
/*
 Behavioural stand-in for the firmware boot sequencer that feeds ssi_top.
 Assumes the bench asks for one report at a time through go_in and code_in.
*/
`timescale 1ns/1ps
module ssi_boot_model
	import ssi_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic go_in,
	input wire logic [2:0] code_in,
	output logic [2:0] boot_event_out
);
	// ==========================================================
	// Report driver
	// Each report is shown for one cycle, then the idle code.
	// Repeats would be harmless, but one cycle proves single sampling.
	always_ff @(posedge clk_in) begin
		if (!rst_b_in || !go_in) begin
			boot_event_out <= SSI_EV_NONE;
		end else begin
			boot_event_out <= code_in;
		end
	end
endmodule

// File: tb/ssi_top_bench.sv
/*
 Self-checking bench for ssi_top: boot phases, errors, hand-over, pins.
 Assumes the boot model and ssi_top share one 250 MHz clock.
*/
`timescale 1ns/1ps
module ssi_top_bench;
	import ssi_pkg::*;
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic go = 1'b0;
	logic ce = 1'b1;
	logic we = 1'b0;
	logic rx = 1'b0;
	logic ntx = 1'b0;
	logic link = 1'b0;
	logic [2:0] code = 3'h0;
	logic [2:0] app = 3'h0;
	logic [1:0] txs = 2'h0;
	logic [6:0] fb = 7'h00;
	logic [2:0] ev;
	logic l1, l2, l3, err, txa, txb, act, lnk, own;
	logic [6:0] fbo;
	int mismatches = 0;
	int checks_done = 0;
	int cyc = 0;

	ssi_boot_model u_ssi_boot_model (.clk_in(clk_in), .rst_b_in(rst_b_in), .go_in(go), .code_in(code),
		.boot_event_out(ev));
	ssi_top u_ssi_top (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce), .boot_event_in(ev),
		.app_lamps_in(app), .app_lamps_we_in(we), .tx_status_in(txs), .net_rx_in(rx), .net_tx_in(ntx),
		.net_link_in(link), .fieldbus_in(fb), .user_lamp_one_out(l1), .user_lamp_two_out(l2),
		.user_lamp_three_out(l3), .error_lamp_out(err), .transmit_status_lamp_a_out(txa),
		.transmit_status_lamp_b_out(txb), .network_activity_lamp_out(act), .network_link_lamp_out(lnk),
		.fieldbus_lamps_out(fbo), .app_owns_lamps_out(own));

	always #2 clk_in = ~clk_in;

	// ==========================================================
	// Common tasks
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk_v(input logic [9:0] exp, input logic [9:0] got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask

	// Pattern order {one, two, three, error} plus ownership flag
	task automatic chk_pat(input logic [3:0] pat, input logic owned);
		chk_v({5'h00, pat, owned}, {5'h00, l1, l2, l3, err, own});
	endtask

	task automatic send(input logic [2:0] c);
		@(posedge clk_in) go <= 1'b1;
		code <= c;
		@(posedge clk_in) go <= 1'b0;
		@(posedge clk_in);
		#1;
	endtask

	// Never issued while the flash phase is running
	task automatic do_reset();
		@(posedge clk_in) rst_b_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		#1;
		chk_pat(4'h0, 1'b0);
		@(posedge clk_in) rst_b_in <= 1'b1;
	endtask

	// Watchdog so that no hang outlives the run budget
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc > 20000) begin
			mismatches++;
			test_done();
		end
	end

	// ==========================================================
	// Scenarios
	task automatic t_boot();
		send(SSI_EV_PL_OK);
		chk_pat(4'h8, 1'b0);
		send(SSI_EV_TC_OK);
		chk_pat(4'hC, 1'b0);
		send(SSI_EV_FLASH_START);
		chk_pat(4'hE, 1'b0);
		// An early application write must neither show now nor survive into ready
		@(posedge clk_in) we <= 1'b1;
		app <= 3'h7;
		@(posedge clk_in) we <= 1'b0;
		#1;
		chk_pat(4'hE, 1'b0);
		send(SSI_EV_READY);
		chk_pat(4'h0, 1'b1);
		@(posedge clk_in) we <= 1'b1;
		app <= 3'h5;
		@(posedge clk_in) we <= 1'b0;
		#1;
		chk_pat(4'hA, 1'b1);
		$display("test boot done");
	endtask

	task automatic t_rt_err();
		do_reset();
		send(SSI_EV_RT_FAIL);
		chk_pat(4'h9, 1'b0);
		send(SSI_EV_READY);
		chk_pat(4'h9, 1'b0);
		$display("test runtime error done");
	endtask

	task automatic t_tc_err();
		do_reset();
		send(SSI_EV_TC_FAIL);
		chk_pat(4'h5, 1'b0);
		send(SSI_EV_DRV_FAIL);
		chk_v(10'h003, {8'h00, txa, txb});
		send(SSI_EV_PL_OK);
		chk_pat(4'h5, 1'b0);
		$display("test coprocessor error done");
	endtask

	// A report and a pin change while disabled must leave the user, error and activity lamps frozen
	task automatic t_freeze();
		do_reset();
		@(posedge clk_in) ce <= 1'b0;
		rx <= 1'b1;
		send(SSI_EV_PL_OK);
		repeat (2) @(posedge clk_in);
		#1;
		chk_pat(4'h0, 1'b0);
		chk_v(10'h000, {9'h000, act});
		@(posedge clk_in) ce <= 1'b1;
		send(SSI_EV_PL_OK);
		chk_pat(4'h8, 1'b0);
		chk_v(10'h001, {9'h000, act});
		@(posedge clk_in) rx <= 1'b0;
		$display("test freeze done");
	endtask

	task automatic t_pins();
		do_reset();
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_in) rx <= i[1];
			ntx <= i[0];
			link <= i[0];
			txs <= i[1:0];
			fb <= 7'h2A + 7'(i);
			repeat (4) @(posedge clk_in);
			#1;
			chk_v({i[1] | i[0], i[0], 7'h2A + 7'(i), 1'b0}, {act, lnk, fbo, 1'b0});
			chk_v({8'h00, i[1:0]}, {8'h00, txa, txb});
		end
		$display("test pins done");
	endtask

	initial begin
		do_reset();
		t_boot();
		do_reset();
		t_rt_err();
		t_tc_err();
		t_freeze();
		t_pins();
		test_done();
	end
endmodule
